// ### dv/laf_exec_asserts.sv
// checker for the and-literal / and-file-register executor
`timescale 1ns/1ps
module laf_exec_chk (
  input wire logic CLK_I,
  input wire logic RST_I,
  input wire logic INSTR_VALID_I,
  input wire logic [13:0] INSTR_I,
  input wire logic INSTR_READY_O,
  input wire logic DONE_O,
  input wire logic [7:0] ACC_O,
  input wire laf_pkg::laf_flags_t FLAGS_O
);
  default clocking cb @(posedge CLK_I);
  endclocking
  default disable iff (RST_I);
  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  logic tk;
  logic lit;
  logic frg;
  assign tk = INSTR_VALID_I && INSTR_READY_O;
  assign lit = tk && (INSTR_I[13:8] == laf_pkg::OPC_AND_LIT);
  assign frg = tk && (INSTR_I[13:8] == laf_pkg::OPC_AND_FREG);
  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  done_latency_a: assert property (tk |-> ##4 DONE_O)
    else $error("done not four cycles after take");
  ready_busy_a: assert property (tk |=> !INSTR_READY_O [*3])
    else $error("ready high while busy");
  lit_result_a: assert property (lit |-> ##4 ACC_O == ($past(ACC_O) & $past(INSTR_I[7:0], 4)))
    else $error("literal and result wrong");
  lit_zero_a: assert property (lit |-> ##4 FLAGS_O.zero == (ACC_O == 8'h00))
    else $error("zero flag wrong");
  carry_hold_a: assert property (1'b1 |=> $stable({FLAGS_O.carry, FLAGS_O.digit_carry}))
    else $error("carry flags changed");
  freg_acc_a: assert property (frg && !INSTR_I[7] |-> ##4 (ACC_O & ~$past(ACC_O)) == 8'h00)
    else $error("file and into accumulator wrong");
  freg_keep_a: assert property (frg && INSTR_I[7] |-> ##4 $stable(ACC_O))
    else $error("accumulator changed on file write");
  cover property (lit);
  cover property (frg && INSTR_I[7]);
  cover property (frg && !INSTR_I[7]);
endmodule
bind laf_exec laf_exec_chk i_chk (.CLK_I(CLK_I), .RST_I(RST_I), .INSTR_VALID_I(INSTR_VALID_I),
  .INSTR_I(INSTR_I), .INSTR_READY_O(INSTR_READY_O), .DONE_O(DONE_O), .ACC_O(ACC_O),
  .FLAGS_O(FLAGS_O));

// ### dv/laf_exec_tb_top.sv
// testbench for the and-literal / and-file-register executor
`timescale 1ns/1ps
module laf_exec_tb_top;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic vld = 1'b0;
  logic [13:0] ins = 14'h0000;
  logic [6:0] dad = 7'h7f;
  logic rdy, done, ill;
  logic [7:0] acc, dbg;
  laf_pkg::laf_flags_t flg;
  int fail_count = 0;
  int comparisons = 0;
  int cyc = 0;
  logic [7:0] acc_m = laf_pkg::ACC_RST;
  logic [7:0] file_m = laf_pkg::FILE_RST;
  laf_exec i_dut (.CLK_I(clk), .RST_I(rst), .INSTR_VALID_I(vld), .INSTR_I(ins),
    .DBG_ADDR_I(dad), .INSTR_READY_O(rdy), .DONE_O(done), .ILLEGAL_O(ill), .ACC_O(acc),
    .FLAGS_O(flg), .DBG_DATA_O(dbg));
  initial begin
    forever #2.5 clk = ~clk;
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  // offer one word, hold until taken, then land in the done cycle
  task automatic issue(input logic [13:0] w);
    @(posedge clk);
    ins <= w;
    vld <= 1'b1;
    do @(posedge clk); while (rdy !== 1'b1);
    vld <= 1'b0;
    // done pulse stands after the third edge past the take
    repeat (3) @(posedge clk);
    #1;
  endtask
  task automatic t_lit;
    logic [7:0] k;
    for (int i = 0; i < 2; i++) begin
      k = (i == 0) ? 8'ha3 : 8'h5f;
      issue({laf_pkg::OPC_AND_LIT, k});
      acc_m = acc_m & k;
      chk({7'h00, done}, 8'h01);
      chk(acc, acc_m);
      chk({5'h00, flg}, {7'h00, acc_m == 8'h00});
    end
    $display("literal test done");
  endtask
  task automatic t_freg;
    logic [7:0] r;
    for (int d = 1; d >= 0; d--) begin
      issue({laf_pkg::OPC_AND_FREG, d[0], 7'h7f});
      r = acc_m & file_m;
      if (d == 1) begin
        file_m = r;
      end else begin
        acc_m = r;
      end
      chk({6'h00, done, ill}, 8'h02);
      chk(acc, acc_m);
      chk({5'h00, flg}, {7'h00, r == 8'h00});
      @(posedge clk);
      #1;
      chk(dbg, file_m);
    end
    $display("file test done");
  endtask
  task automatic t_illegal;
    // add forms are outside this block and must be flagged
    issue({6'h3e, 8'h12});
    chk({6'h00, done, ill}, 8'h03);
    chk(acc, acc_m);
    chk({5'h00, flg}, {7'h00, acc_m == 8'h00});
    $display("illegal test done");
  endtask
  task automatic t_zero;
    issue({laf_pkg::OPC_AND_LIT, 8'h00});
    acc_m = 8'h00;
    chk(acc, acc_m);
    chk({5'h00, flg}, 8'h01);
    $display("zero test done");
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 2000) begin
      fail_count++;
      report_and_stop;
    end
  end
  initial begin
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    t_lit;
    t_freg;
    t_illegal;
    t_zero;
    report_and_stop;
  end
endmodule

// ### hdl/laf_exec.sv
// four-phase executor for and-with-literal and and-with-file-register
`timescale 1ns/1ps
module laf_exec (
  input wire logic CLK_I,
  input wire logic RST_I,
  input wire logic INSTR_VALID_I,
  input wire logic [13:0] INSTR_I,
  input wire logic [6:0] DBG_ADDR_I,
  output logic INSTR_READY_O,
  output logic DONE_O,
  output logic ILLEGAL_O,
  output logic [7:0] ACC_O,
  output laf_pkg::laf_flags_t FLAGS_O,
  output logic [7:0] DBG_DATA_O
);

  // ---------------------------------------------------------------
  // decode
  // ---------------------------------------------------------------
  function automatic laf_pkg::laf_decode_t decode_instr(input logic [13:0] w);
    laf_pkg::laf_decode_t d;
    logic [5:0] opc;
    opc = w[laf_pkg::OPC_POS +: laf_pkg::OPC_W];
    d.is_lit = (opc == laf_pkg::OPC_AND_LIT);
    d.is_freg = (opc == laf_pkg::OPC_AND_FREG);
    d.dest_file = w[laf_pkg::DEST_POS];
    d.faddr = w[laf_pkg::FADDR_POS +: laf_pkg::FADDR_W];
    d.literal = w[laf_pkg::LIT_POS +: laf_pkg::DATA_W];
    return d;
  endfunction

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  laf_pkg::laf_phase_t phase_q, phase_d;
  laf_pkg::laf_decode_t dec_q, dec_d;
  logic [7:0] opnd_q, opnd_d;
  logic [7:0] res_q, res_d;
  logic zero_res_q, zero_res_d;
  logic [7:0] acc_q, acc_d;
  laf_pkg::laf_flags_t flags_q, flags_d;
  logic done_q, done_d;
  logic illegal_q, illegal_d;
  logic ready_q, ready_d;
  logic [7:0] dbg_q, dbg_d;
  // file registers kept local; small enough for flops
  logic [7:0] file_q [laf_pkg::FILE_DEPTH];
  logic file_we;
  logic [7:0] alu_res;
  logic alu_zero;
  logic take;

  laf_logic_unit u_and (
    .a_i(acc_q),
    .b_i(opnd_q),
    .res_o(alu_res),
    .zero_o(alu_zero)
  );

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    dec_d = dec_q;
    opnd_d = opnd_q;
    res_d = res_q;
    zero_res_d = zero_res_q;
    acc_d = acc_q;
    flags_d = flags_q;
    done_d = 1'b0;
    illegal_d = 1'b0;
    file_we = 1'b0;
    unique case (phase_q)
      laf_pkg::PH_DECODE: begin
        if (take) begin
          dec_d = decode_instr(INSTR_I);
        end
      end
      laf_pkg::PH_READ: begin
        opnd_d = dec_q.is_lit ? dec_q.literal : file_q[dec_q.faddr];
      end
      laf_pkg::PH_PROCESS: begin
        res_d = alu_res;
        zero_res_d = alu_zero;
      end
      laf_pkg::PH_WRITE: begin
        done_d = 1'b1;
        if (dec_q.is_lit || dec_q.is_freg) begin
          flags_d.zero = zero_res_q;
          if (dec_q.is_freg && dec_q.dest_file) begin
            file_we = 1'b1;
          end else begin
            acc_d = res_q;
          end
        end else begin
          // unsupported opcode: no state change
          illegal_d = 1'b1;
        end
      end
      default: begin
        // stray phase code: nothing is committed
        done_d = 1'b0;
      end
    endcase
  end

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      dec_q <= '0;
      opnd_q <= laf_pkg::ACC_RST;
      res_q <= laf_pkg::ACC_RST;
      zero_res_q <= 1'b0;
      acc_q <= laf_pkg::ACC_RST;
      flags_q <= laf_pkg::FLAGS_RST;
      done_q <= 1'b0;
      illegal_q <= 1'b0;
    end else begin
      dec_q <= dec_d;
      opnd_q <= opnd_d;
      res_q <= res_d;
      zero_res_q <= zero_res_d;
      acc_q <= acc_d;
      flags_q <= flags_d;
      done_q <= done_d;
      illegal_q <= illegal_d;
    end
  end

  // ---------------------------------------------------------------
  // phase sequencer
  // ---------------------------------------------------------------
  assign take = INSTR_VALID_I && ready_q;

  always_comb begin
    phase_d = phase_q;
    ready_d = 1'b0;
    unique case (phase_q)
      laf_pkg::PH_DECODE: begin
        ready_d = 1'b1;
        if (take) begin
          ready_d = 1'b0;
          phase_d = laf_pkg::PH_READ;
        end
      end
      laf_pkg::PH_READ: begin
        phase_d = laf_pkg::PH_PROCESS;
      end
      laf_pkg::PH_PROCESS: begin
        phase_d = laf_pkg::PH_WRITE;
      end
      laf_pkg::PH_WRITE: begin
        // ready early so words can follow back to back
        ready_d = 1'b1;
        phase_d = laf_pkg::PH_DECODE;
      end
      default: begin
        phase_d = laf_pkg::PH_DECODE;
      end
    endcase
  end

  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      phase_q <= laf_pkg::PH_DECODE;
      ready_q <= 1'b0;
    end else begin
      phase_q <= phase_d;
      ready_q <= ready_d;
    end
  end

  // ---------------------------------------------------------------
  // observation port
  // ---------------------------------------------------------------
  // one cycle late: a write shows on the following cycle
  always_comb begin
    dbg_d = file_q[DBG_ADDR_I];
  end

  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      dbg_q <= laf_pkg::FILE_RST;
    end else begin
      dbg_q <= dbg_d;
    end
  end

  // ---------------------------------------------------------------
  // file registers
  // ---------------------------------------------------------------
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      for (int i = 0; i < laf_pkg::FILE_DEPTH; i++) begin
        file_q[i] <= laf_pkg::FILE_RST;
      end
    end else if (file_we) begin
      file_q[dec_q.faddr] <= res_q;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign INSTR_READY_O = ready_q;
  assign DONE_O = done_q;
  assign ILLEGAL_O = illegal_q;
  assign ACC_O = acc_q;
  assign FLAGS_O = flags_q;
  assign DBG_DATA_O = dbg_q;

endmodule

// ### hdl/laf_logic_unit.sv
// combinational and-unit with zero detect
`timescale 1ns/1ps
module laf_logic_unit (
  input wire logic [7:0] a_i,
  input wire logic [7:0] b_i,
  output logic [7:0] res_o,
  output logic zero_o
);

  always_comb begin
    res_o = a_i & b_i;
    zero_o = (res_o == 8'h00);
  end

endmodule

// ### hdl/laf_pkg.sv
// package for the and-literal / and-file-register execution block
package laf_pkg;

  // ---------------------------------------------------------------
  // widths and encodings
  // ---------------------------------------------------------------
  localparam int DATA_W = 8;
  localparam int INSTR_W = 14;
  localparam int FADDR_W = 7;
  localparam int FILE_DEPTH = 128;

  // opcode fields: top six bits of the instruction word
  localparam int OPC_POS = 8;
  localparam int OPC_W = 6;
  localparam logic [5:0] OPC_AND_LIT = 6'h39;
  localparam logic [5:0] OPC_AND_FREG = 6'h05;
  localparam int DEST_POS = 7;
  localparam int FADDR_POS = 0;
  localparam int LIT_POS = 0;

  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  // nonzero so that and results stay observable after reset
  localparam logic [7:0] ACC_RST = 8'hff;
  localparam logic [7:0] FILE_RST = 8'h5e;
  localparam logic [2:0] FLAGS_RST = 3'h0;

  // cycles per instruction (one four-phase cycle, one clock each phase)
  localparam int PHASES = 4;

  // ---------------------------------------------------------------
  // types
  // ---------------------------------------------------------------
  typedef enum logic [3:0] {
    PH_DECODE  = 4'h1,
    PH_READ    = 4'h2,
    PH_PROCESS = 4'h4,
    PH_WRITE   = 4'h8
  } laf_phase_t;

  typedef struct packed {
    logic carry;
    logic digit_carry;
    logic zero;
  } laf_flags_t;

  typedef struct packed {
    logic is_lit;
    logic is_freg;
    logic dest_file;
    logic [6:0] faddr;
    logic [7:0] literal;
  } laf_decode_t;

endpackage
